// [core/host_port_regs.sv]
/*
 * Host port address and data registers with read/write FIFOs and the DMA
 * engine that moves words between them and internal memory.
 * Assumes host pins are asynchronous to MCLK and held stable around the
 * strobe; DMA and local CPU ports are synchronous to MCLK.
 */
`timescale 1ns/1ps
module host_port_regs (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    // Host multiplexed bus pins
    input  wire logic        HSTB_N,
    input  wire logic [1:0]  HSEL,
    input  wire logic        HRW,
    input  wire logic        HHALF,
    input  wire logic [31:0] HD_IN,
    output logic      [31:0] HD_OUT,
    output logic             HD_OE,
    output logic             HRDY,
    // Mode straps
    input  wire logic        MODE16,
    input  wire logic        DUAL_ADDR,
    // Local CPU read port for the address registers
    input  wire logic        CPU_RD,
    input  wire logic        CPU_SEL,
    output logic      [31:0] CPU_RDATA,
    // Internal memory DMA port
    output logic             DMA_REQ,
    output logic             DMA_WE,
    output logic      [31:0] DMA_ADDR,
    output logic      [31:0] DMA_WDATA,
    input  wire logic        DMA_ACK,
    input  wire logic [31:0] DMA_RDATA
);
    import hp_pkg::*;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    host_acc_s   pin_m_r, pin_s_r;
    logic [3:0]  lvl_m_r, lvl_s_r;
    logic        stb_d_r;
    logic        stb_n_s, rw_s, mode16_s, dual_s, stb_fall;

    // Two flops on every pin; only the second stage is used by logic
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_m_r <= '0;
            pin_s_r <= '0;
            lvl_m_r <= 4'h1;
            lvl_s_r <= 4'h1;
            stb_d_r <= 1'b1;
        end else begin
            pin_m_r <= '{sel: HSEL, rd: HRW, second: HHALF, data: HD_IN};
            pin_s_r <= pin_m_r;
            lvl_m_r <= {MODE16, DUAL_ADDR, HRW, HSTB_N};
            lvl_s_r <= lvl_m_r;
            stb_d_r <= stb_n_s;
        end
    end

    assign stb_n_s  = lvl_s_r[0];
    assign rw_s     = lvl_s_r[1];
    assign dual_s   = lvl_s_r[2];
    assign mode16_s = lvl_s_r[3];
    assign stb_fall = stb_d_r && !stb_n_s;

    // ---------------------------------------------------------------
    // FIFOs between the data register and the DMA engine
    // ---------------------------------------------------------------
    logic        wf_in_valid, wf_in_ready, wf_out_valid, wf_out_ready;
    logic [31:0] wf_in_data, wf_out_data;
    logic        rf_in_valid, rf_in_ready, rf_out_valid, rf_out_ready;
    logic [31:0] rf_out_data;
    logic        ra_written;

    // Host data writes land here; DMA drains it
    word_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_wfifo (
        .clk       (MCLK),
        .rst_n     (RSTN),
        .flush     (1'b0),
        .in_valid  (wf_in_valid),
        .in_ready  (wf_in_ready),
        .in_data   (wf_in_data),
        .out_valid (wf_out_valid),
        .out_ready (wf_out_ready),
        .out_data  (wf_out_data)
    );

    // DMA fills this ahead of host data reads; a new read address flushes it
    word_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rfifo (
        .clk       (MCLK),
        .rst_n     (RSTN),
        .flush     (ra_written),
        .in_valid  (rf_in_valid),
        .in_ready  (rf_in_ready),
        .in_data   (DMA_RDATA),
        .out_valid (rf_out_valid),
        .out_ready (rf_out_ready),
        .out_data  (rf_out_data)
    );

    // ---------------------------------------------------------------
    // Host side: registers and access sequencing
    // ---------------------------------------------------------------
    host_state_e hst_r, hst_nxt;
    host_acc_s   acc_r, acc_nxt;
    logic [31:0] waddr_r, waddr_nxt, raddr_r, raddr_nxt;
    logic [31:0] data_r, data_nxt;
    logic        order_r, order_nxt, prefetch_r, prefetch_nxt;
    logic [31:0] hd_out_r, hd_out_nxt, cpu_rdata_r, cpu_rdata_nxt;
    logic        hd_oe_r, hd_oe_nxt, hrdy_r, hrdy_nxt;
    logic        wa_inc, ra_inc;

    // Place one host piece into a word: whole word, or the chosen half
    function automatic logic [31:0] put_half(input logic [31:0] old, input logic [31:0] d,
                                             input logic m16, input logic hi);
        if (!m16)
            put_half = d;
        else if (hi)
            put_half = {d[15:0], old[15:0]};
        else
            put_half = {old[31:16], d[15:0]};
    endfunction

    always_comb begin
        logic        hi, last, first;
        logic [31:0] merged, src;
        hi            = (acc_r.second == order_r);
        last          = !mode16_s || acc_r.second;
        first         = !mode16_s || !acc_r.second;
        merged        = '0;
        src           = '0;
        hst_nxt       = hst_r;
        acc_nxt       = acc_r;
        waddr_nxt     = wa_inc ? waddr_r + ADDR_STEP : waddr_r;
        raddr_nxt     = ra_inc ? raddr_r + ADDR_STEP : raddr_r;
        data_nxt      = data_r;
        order_nxt     = order_r;
        prefetch_nxt  = prefetch_r;
        ra_written    = 1'b0;
        wf_in_valid   = 1'b0;
        wf_in_data    = data_r;
        rf_out_ready  = 1'b0;
        unique case (hst_r)
            H_IDLE: begin
                if (stb_fall) begin
                    acc_nxt = pin_s_r;
                    hst_nxt = H_EXEC;
                end
            end
            H_EXEC: begin
                hst_nxt = H_IDLE;
                unique case (acc_r.sel)
                    SEL_CTRL: begin
                        if (!acc_r.rd) begin
                            merged    = put_half({27'h0, 1'b0, 3'h0, order_r}, acc_r.data, mode16_s, hi);
                            order_nxt = merged[CTRL_ORDER_BIT];
                            if (merged[CTRL_FETCH_BIT]) prefetch_nxt = 1'b1;
                        end
                    end
                    SEL_RADDR, SEL_WADDR: begin
                        // Host owns both address registers; local CPU path is read only
                        if (!acc_r.rd) begin
                            merged = put_half((acc_r.sel == SEL_RADDR) ? raddr_r : waddr_r,
                                              acc_r.data, mode16_s, hi);
                            if (acc_r.sel == SEL_RADDR || !dual_s) begin
                                raddr_nxt    = merged;
                                ra_written   = 1'b1;
                                prefetch_nxt = 1'b0;
                            end
                            if (acc_r.sel == SEL_WADDR || !dual_s) begin
                                waddr_nxt = merged;
                            end
                        end
                    end
                    SEL_DATA: begin
                        if (!acc_r.rd) begin
                            merged = put_half(data_r, acc_r.data, mode16_s, hi);
                            if (last) begin
                                // Whole word only; stall on a full write FIFO
                                wf_in_data  = merged;
                                wf_in_valid = 1'b1;
                                if (wf_in_ready) data_nxt = merged;
                                else hst_nxt = H_EXEC;
                            end else begin
                                data_nxt = merged;
                            end
                        end else if (first) begin
                            // Word must be in the data register before any half goes out
                            rf_out_ready = 1'b1;
                            if (rf_out_valid) begin
                                data_nxt = rf_out_data;
                            end else begin
                                prefetch_nxt = 1'b1;
                                hst_nxt      = H_EXEC;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        endcase
        // Read value for the selected register; prefetch bit always reads 0
        unique case (acc_r.sel)
            SEL_CTRL:  src = {31'h0, order_r};
            SEL_RADDR: src = raddr_r;
            SEL_WADDR: src = waddr_r;
            default:   src = data_r;
        endcase
        hd_out_nxt    = mode16_s ? {16'h0, hi ? src[31:16] : src[15:0]} : src;
        hd_oe_nxt     = !stb_n_s && rw_s;
        hrdy_nxt      = (hst_r == H_IDLE);
        // Local CPU sees addresses only; nothing reaches the data register
        cpu_rdata_nxt = CPU_RD ? (CPU_SEL ? raddr_r : waddr_r) : cpu_rdata_r;
    end

    // Hardware reset clears every register of this group except hrdy_r, which resets high
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            hst_r       <= H_IDLE;
            acc_r       <= '0;
            waddr_r     <= ADDR_RESET;
            raddr_r     <= ADDR_RESET;
            data_r      <= DATA_RESET;
            order_r     <= ORDER_RESET;
            prefetch_r  <= 1'b0;
            hd_out_r    <= DATA_RESET;
            hd_oe_r     <= 1'b0;
            hrdy_r      <= 1'b1;
            cpu_rdata_r <= ADDR_RESET;
        end else begin
            hst_r       <= hst_nxt;
            acc_r       <= acc_nxt;
            waddr_r     <= waddr_nxt;
            raddr_r     <= raddr_nxt;
            data_r      <= data_nxt;
            order_r     <= order_nxt;
            prefetch_r  <= prefetch_nxt;
            hd_out_r    <= hd_out_nxt;
            hd_oe_r     <= hd_oe_nxt;
            hrdy_r      <= hrdy_nxt;
            cpu_rdata_r <= cpu_rdata_nxt;
        end
    end

    // ---------------------------------------------------------------
    // DMA engine: one outstanding access, writes before prefetch reads
    // ---------------------------------------------------------------
    dma_state_e  dst_r, dst_nxt;
    logic        dreq_r, dreq_nxt, dwe_r, dwe_nxt, stale_r, stale_nxt;
    logic [31:0] daddr_r, daddr_nxt, dwdata_r, dwdata_nxt;

    always_comb begin
        dst_nxt      = dst_r;
        dreq_nxt     = dreq_r;
        dwe_nxt      = dwe_r;
        daddr_nxt    = daddr_r;
        dwdata_nxt   = dwdata_r;
        stale_nxt    = stale_r || ra_written;
        wf_out_ready = 1'b0;
        rf_in_valid  = 1'b0;
        wa_inc       = 1'b0;
        ra_inc       = 1'b0;
        unique case (dst_r)
            D_IDLE: begin
                stale_nxt = 1'b0;
                if (wf_out_valid) begin
                    wf_out_ready = 1'b1;
                    dreq_nxt     = 1'b1;
                    dwe_nxt      = 1'b1;
                    daddr_nxt    = waddr_r << BYTE_SHIFT;
                    dwdata_nxt   = wf_out_data;
                    dst_nxt      = D_WRITE;
                end else if (prefetch_r && rf_in_ready && !ra_written) begin
                    dreq_nxt  = 1'b1;
                    dwe_nxt   = 1'b0;
                    daddr_nxt = raddr_r << BYTE_SHIFT;
                    dst_nxt   = D_READ;
                end
            end
            D_WRITE: begin
                if (DMA_ACK) begin
                    dreq_nxt = 1'b0;
                    dwe_nxt  = 1'b0;
                    wa_inc   = 1'b1;
                    dst_nxt  = D_IDLE;
                end
            end
            D_READ: begin
                // A read address rewritten mid-fetch makes this word stale
                if (DMA_ACK) begin
                    rf_in_valid = !stale_nxt;
                    ra_inc      = !stale_nxt;
                    dreq_nxt    = 1'b0;
                    dst_nxt     = D_IDLE;
                end
            end
            default: begin
                dreq_nxt = 1'b0;
                dwe_nxt  = 1'b0;
                dst_nxt  = D_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            dst_r    <= D_IDLE;
            dreq_r   <= 1'b0;
            dwe_r    <= 1'b0;
            daddr_r  <= ADDR_RESET;
            dwdata_r <= DATA_RESET;
            stale_r  <= 1'b0;
        end else begin
            dst_r    <= dst_nxt;
            dreq_r   <= dreq_nxt;
            dwe_r    <= dwe_nxt;
            daddr_r  <= daddr_nxt;
            dwdata_r <= dwdata_nxt;
            stale_r  <= stale_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs, all from flops
    // ---------------------------------------------------------------
    assign HD_OUT    = hd_out_r;
    assign HD_OE     = hd_oe_r;
    assign HRDY      = hrdy_r;
    assign CPU_RDATA = cpu_rdata_r;
    assign DMA_REQ   = dreq_r;
    assign DMA_WE    = dwe_r;
    assign DMA_ADDR  = daddr_r;
    assign DMA_WDATA = dwdata_r;
endmodule

// [core/hp_pkg.sv]
/*
 * Shared constants, types and state codes for the host port address/data
 * register block, its FIFOs and its memory.
 * Assumes a single clock domain; host_port_regs, word_fifo and the bench import this package.
 */
package hp_pkg;

    // ---------------------------------------------------------------
    // Widths, depths and counts
    // ---------------------------------------------------------------
    localparam int          WORD_W        = 32;
    localparam int          HALF_W        = 16;
    localparam int          FIFO_DEPTH    = 32;
    localparam int          FIFO_AW       = 5;
    localparam int          BYTE_SHIFT    = 2;
    localparam logic [31:0] ADDR_STEP     = 32'h0000_0001;

    // ---------------------------------------------------------------
    // Host register select codes and control field positions
    // ---------------------------------------------------------------
    localparam logic [1:0]  SEL_CTRL      = 2'h0;
    localparam logic [1:0]  SEL_RADDR     = 2'h1;
    localparam logic [1:0]  SEL_WADDR     = 2'h2;
    localparam logic [1:0]  SEL_DATA      = 2'h3;
    localparam int          CTRL_ORDER_BIT = 0;
    localparam int          CTRL_FETCH_BIT = 4;

    // ---------------------------------------------------------------
    // Values after reset
    // ---------------------------------------------------------------
    localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET    = 32'h0000_0000;
    localparam logic        ORDER_RESET   = 1'b0;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  sel;
        logic        rd;
        logic        second;
        logic [31:0] data;
    } host_acc_s;

    typedef enum logic [0:0] {
        H_IDLE = 1'b0,
        H_EXEC = 1'b1
    } host_state_e;

    typedef enum logic [1:0] {
        D_IDLE  = 2'b00,
        D_WRITE = 2'b01,
        D_READ  = 2'b10
    } dma_state_e;

endpackage

// [core/word_fifo.sv]
/*
 * Show-ahead FIFO with valid/ready on both sides and a synchronous flush.
 * Assumes one clock; head word is held in the memory's read register.
 */
`timescale 1ns/1ps
module word_fifo
    import hp_pkg::*;
#(
    parameter int W     = 32,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         flush,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    // Honest flags straight from the occupancy count
    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;

    // Pointer and count update; flush empties without touching storage
    always_comb begin
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (flush) begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end else begin
            if (push) wp_nxt = wp_r + AW'(1);
            if (pop)  rp_nxt = rp_r + AW'(1);
            cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Memory reads the next head so out_data always shows rp_r's word
    word_mem #(.W(W), .AW(AW)) u_mem (
        .clk   (clk),
        .we    (push),
        .waddr (wp_r),
        .wdata (in_data),
        .raddr (rp_nxt),
        .rdata (out_data)
    );
endmodule

// [core/word_mem.sv]
/*
 * Small two-port word memory with registered read data.
 * Assumes one clock; a read of the address being written returns new data.
 */
`timescale 1ns/1ps
module word_mem #(
    parameter int W  = 32,
    parameter int AW = 5
) (
    // Clock
    input  wire logic          clk,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);
    logic [W-1:0] mem [0:(1<<AW)-1];
    logic [W-1:0] rdata_nxt;

    // Write-through so a FIFO head written while empty is seen at once
    always_comb begin
        rdata_nxt = (we && (waddr == raddr)) ? wdata : mem[raddr];
    end

    // Storage has no reset; contents are only read behind a valid count
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= rdata_nxt;
    end
endmodule

// [dv/host_bus_model.sv]
/* Host processor model driving the multiplexed host bus.
   Assumes MCLK from the bench; waits on ready before releasing a cycle. */
`timescale 1ns/1ps
module host_bus_model (
    // Clock
    input  wire logic        MCLK,
    // Host bus
    output logic             HSTB_N,
    output logic [1:0]       HSEL,
    output logic             HRW,
    output logic             HHALF,
    output logic [31:0]      HD_IN,
    input  wire logic [31:0] HD_OUT,
    input  wire logic        HRDY
);
    // Run-out waits are counted here and added in at the verdict
    int miss = 0;
    initial begin
        HSTB_N = 1'b1;
        HSEL   = 2'h0;
        HRW    = 1'b1;
        HHALF  = 1'b0;
        HD_IN  = 32'h0;
    end
    // One strobed cycle; pins held until ready is seen high
    task automatic acc(input logic [1:0] s, input logic rw, input logic hf,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge MCLK); #1;
        HSEL = s; HRW = rw; HHALF = hf; HD_IN = d; HSTB_N = 1'b0;
        n = 0;
        while (HRDY !== 1'b0 && n < 20) begin @(posedge MCLK); #1; n++; end
        if (n == 20) miss++;
        n = 0;
        while (HRDY !== 1'b1 && n < 400) begin @(posedge MCLK); #1; n++; end
        if (n == 400) miss++;
        q = HD_OUT;
        HSTB_N = 1'b1;
        HD_IN = ~d; // Released data never shows the old word
        repeat (4) @(posedge MCLK);
    endtask
endmodule

// [dv/host_port_regs_properties.sv]
/* Concurrent checks on the host port register block outputs.
   Assumes it is bound to host_port_regs from the bench top. */
`timescale 1ns/1ps
module host_port_regs_properties (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RSTN,
    // Host side
    input wire logic        HSTB_N,
    input wire logic        HD_OE,
    input wire logic        HRDY,
    // CPU side
    input wire logic        CPU_RD,
    input wire logic [31:0] CPU_RDATA,
    // DMA side
    input wire logic        DMA_REQ,
    input wire logic        DMA_WE,
    input wire logic [31:0] DMA_ADDR,
    input wire logic [31:0] DMA_WDATA,
    input wire logic        DMA_ACK
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_rst_clear; $rose(RSTN) |-> !DMA_REQ && !HD_OE && HRDY && CPU_RDATA == 32'h0; endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
    property p_req_hold; DMA_REQ && !DMA_ACK |=> DMA_REQ && $stable(DMA_ADDR) && $stable(DMA_WE); endproperty
    a_req_hold: assert property (p_req_hold) else $error("dma request changed before ack");
    property p_wdata; DMA_REQ && DMA_WE && !DMA_ACK |=> $stable(DMA_WDATA); endproperty
    a_wdata: assert property (p_wdata) else $error("dma write data changed before ack");
    property p_req_done; DMA_REQ && DMA_ACK |=> !DMA_REQ; endproperty
    a_req_done: assert property (p_req_done) else $error("dma request held after ack");
    property p_word_addr; DMA_REQ |-> DMA_ADDR[1:0] == 2'h0; endproperty
    a_word_addr: assert property (p_word_addr) else $error("dma address not word aligned");
    property p_cpu_hold; !CPU_RD |=> $stable(CPU_RDATA); endproperty
    a_cpu_hold: assert property (p_cpu_hold) else $error("cpu read data moved without a read");
    property p_idle_rdy; HSTB_N [*5] |-> HRDY; endproperty
    a_idle_rdy: assert property (p_idle_rdy) else $error("ready low with no host cycle");
    property p_idle_oe; HSTB_N [*4] |-> !HD_OE; endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("bus driven with no host cycle");
    // Main scenarios reached
    c_wr: cover property (DMA_REQ && DMA_ACK && DMA_WE);
    c_rd: cover property (DMA_REQ && DMA_ACK && !DMA_WE);
    c_stall: cover property (!HRDY [*3]);
    c_oe: cover property (HD_OE && HRDY);
endmodule

// [dv/test_host_port_regs.sv]
/* Self-checking bench: host model, CPU read task and memory responder.
   Assumes the hp_pkg package and the host_port_regs design are compiled first. */
`timescale 1ns/1ps
module test_host_port_regs;
    import hp_pkg::*;
    logic MCLK, RSTN, HSTB_N, HRW, HHALF, HD_OE, HRDY, MODE16, DUAL_ADDR, CPU_RD, CPU_SEL;
    logic DMA_REQ, DMA_WE, DMA_ACK, ho;
    logic [1:0] HSEL;
    logic [31:0] HD_IN, HD_OUT, CPU_RDATA, DMA_ADDR, DMA_WDATA, DMA_RDATA, q, w;
    logic [31:0] mem [logic [29:0]];
    int err_total = 0, n_compared = 0, lat = 0;
    host_bus_model hb (.MCLK(MCLK), .HSTB_N(HSTB_N), .HSEL(HSEL), .HRW(HRW), .HHALF(HHALF),
        .HD_IN(HD_IN), .HD_OUT(HD_OUT), .HRDY(HRDY));
    host_port_regs uut (.MCLK(MCLK), .RSTN(RSTN), .HSTB_N(HSTB_N), .HSEL(HSEL), .HRW(HRW),
        .HHALF(HHALF), .HD_IN(HD_IN), .HD_OUT(HD_OUT), .HD_OE(HD_OE), .HRDY(HRDY), .MODE16(MODE16),
        .DUAL_ADDR(DUAL_ADDR), .CPU_RD(CPU_RD), .CPU_SEL(CPU_SEL), .CPU_RDATA(CPU_RDATA),
        .DMA_REQ(DMA_REQ), .DMA_WE(DMA_WE), .DMA_ADDR(DMA_ADDR), .DMA_WDATA(DMA_WDATA),
        .DMA_ACK(DMA_ACK), .DMA_RDATA(DMA_RDATA));
    // ----------------------------------------
    // Clock, reset, memory responder
    // ----------------------------------------
    initial begin MCLK = 0; forever #5 MCLK = ~MCLK; end
    // Memory answers after lat cycles; data toggles when not acknowledged
    initial begin
        DMA_ACK = 0; DMA_RDATA = 32'h0;
        forever begin
            @(posedge MCLK); #1;
            DMA_ACK = 0; DMA_RDATA = ~DMA_RDATA;
            if (DMA_REQ === 1'b1) begin
                repeat (lat) @(posedge MCLK);
                #1;
                if (DMA_WE) mem[DMA_ADDR[31:2]] = DMA_WDATA;
                else DMA_RDATA = mem.exists(DMA_ADDR[31:2]) ? mem[DMA_ADDR[31:2]] : 32'h0;
                DMA_ACK = 1;
            end
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin err_total++; $display("unexpected %s expected %h seen %h", nm, exp, got); end
    endtask
    task automatic cpu_rd(input logic sel, output logic [31:0] r);
        @(posedge MCLK); #1; CPU_RD = 1; CPU_SEL = sel;
        @(posedge MCLK); #1; CPU_RD = 0; r = CPU_RDATA;
    endtask
    // Halfword order picks which half goes first
    task automatic wr16(input logic [1:0] s, input logic [31:0] v);
        logic [31:0] t;
        hb.acc(s, 0, 0, {16'h0, ho ? v[15:0] : v[31:16]}, t);
        hb.acc(s, 0, 1, {16'h0, ho ? v[31:16] : v[15:0]}, t);
    endtask
    task automatic rd16(input logic [1:0] s, output logic [31:0] r);
        logic [31:0] a, b;
        hb.acc(s, 1, 0, 32'h0, a);
        hb.acc(s, 1, 1, 32'h0, b);
        r = ho ? {b[15:0], a[15:0]} : {a[15:0], b[15:0]};
    endtask
    task automatic end_sim;
        err_total += hb.miss;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin repeat (30000) @(posedge MCLK); err_total++; end_sim; end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        RSTN = 0; MODE16 = 0; DUAL_ADDR = 1; CPU_RD = 0; CPU_SEL = 0; ho = 0;
        repeat (12) @(posedge MCLK);
        #1 RSTN = 1;
        repeat (3) @(posedge MCLK);
        cpu_rd(1, q); chk("read address", 32'h0, q);
        cpu_rd(0, q); chk("write address", 32'h0, q);
        hb.acc(SEL_WADDR, 0, 0, 32'h0020_0000, q);
        hb.acc(SEL_RADDR, 0, 0, 32'h0000_0100, q);
        cpu_rd(0, q); chk("write address", 32'h0020_0000, q);
        cpu_rd(1, q); chk("read address", 32'h0000_0100, q);
        hb.acc(SEL_WADDR, 1, 0, 32'h0, q); chk("host address", 32'h0020_0000, q);
        hb.acc(SEL_DATA, 0, 0, 32'ha5a5_1234, q);
        lat = 3;
        hb.acc(SEL_DATA, 0, 0, 32'h5a5a_8765, q);
        repeat (20) @(posedge MCLK);
        chk("memory word", 32'ha5a5_1234, mem[30'h0020_0000]);
        chk("memory next", 32'h5a5a_8765, mem[30'h0020_0001]);
        hb.acc(SEL_RADDR, 0, 0, 32'h0020_0000, q);
        hb.acc(SEL_DATA, 1, 0, 32'h0, q); chk("read data", 32'ha5a5_1234, q);
        hb.acc(SEL_DATA, 1, 0, 32'h0, q); chk("read next", 32'h5a5a_8765, q);
        hb.acc(SEL_CTRL, 0, 0, 32'h0000_0011, q);
        hb.acc(SEL_CTRL, 1, 0, 32'h0, q); chk("control", 32'h1, q);
        DUAL_ADDR = 0;
        repeat (4) @(posedge MCLK);
        hb.acc(SEL_WADDR, 0, 0, 32'h0000_0300, q);
        cpu_rd(1, q); chk("shared address", 32'h0000_0300, q);
        MODE16 = 1; lat = 0;
        repeat (4) @(posedge MCLK);
        for (int o = 0; o < 2; o++) begin
            wr16(SEL_CTRL, {31'h0, o[0]});
            ho = o[0];
            w = 32'h0000_0400 + o;
            wr16(SEL_WADDR, w);
            wr16(SEL_DATA, 32'hc0de_7700 + o);
            repeat (10) @(posedge MCLK);
            chk("half write", 32'hc0de_7700 + o, mem[w[29:0]]);
            wr16(SEL_RADDR, w);
            rd16(SEL_DATA, q); chk("half read", 32'hc0de_7700 + o, q);
        end
        // Second reset in mid-run, with both address registers non-zero
        @(posedge MCLK); #1 RSTN = 0;
        repeat (2) @(posedge MCLK);
        #1 RSTN = 1;
        repeat (3) @(posedge MCLK);
        cpu_rd(0, q); chk("write address after reset", 32'h0, q);
        cpu_rd(1, q); chk("read address after reset", 32'h0, q);
        end_sim;
    end
endmodule
bind host_port_regs host_port_regs_properties chk_i (.MCLK(MCLK), .RSTN(RSTN), .HSTB_N(HSTB_N),
    .HD_OE(HD_OE), .HRDY(HRDY), .CPU_RD(CPU_RD), .CPU_RDATA(CPU_RDATA), .DMA_REQ(DMA_REQ),
    .DMA_WE(DMA_WE), .DMA_ADDR(DMA_ADDR), .DMA_WDATA(DMA_WDATA), .DMA_ACK(DMA_ACK));
